// *** rtl/fpo_consts.svh ***
`ifndef FPO_CONSTS_SVH
`define FPO_CONSTS_SVH
// register byte offsets
`define FPO_OFF_CMD0      12'h000
`define FPO_OFF_CMD1      12'h004
`define FPO_OFF_CMD2      12'h008
`define FPO_OFF_CMD3      12'h00c
`define FPO_OFF_INDEX     12'h010
`define FPO_OFF_STATUS    12'h014
`define FPO_OFF_CONFIG    12'h018
`define FPO_OFF_ERRCFG    12'h01c
`define FPO_OFF_ERRSTAT   12'h020
`define FPO_OFF_PFPROT    12'h024
`define FPO_OFF_EEPROT    12'h028
`define FPO_OFF_PROTSTAT  12'h02c
`define FPO_OFF_CTRL      12'h030
// command code and keys
`define FPO_CMD_OVERRIDE  8'h13
`define FPO_KEY_ERASED    16'hffff
// parameter index values
`define FPO_IDX_1         3'h1
`define FPO_IDX_2         3'h2
`define FPO_IDX_3         3'h3
// status bit positions
`define FPO_ST_COMMAND_COMPLETE_FLAG       7
`define FPO_ST_ACCESS_ERROR_FLAG     5
`define FPO_ST_PROTECTION_VIOLATION_FLAG     4
// command word fields and config bit positions
`define FPO_CODE_HI       15
`define FPO_CODE_LO       8
`define FPO_SEL_HI        1
`define FPO_SEL_LO        0
`define FPO_CFG_IRQEN     7
// reset values and bus response codes
`define FPO_PROT_RST      8'h00
`define FPO_RESP_OKAY     2'h0
`define FPO_RESP_SLVERR   2'h2
`endif

// *** rtl/fpo_pkg.sv ***
`default_nettype none
package fpo_pkg;
  typedef enum logic [1:0] {FPO_IDLE, FPO_EXEC, FPO_DONE} fpo_state_e;
  typedef logic [15:0] fpo_word_t;
endpackage
`default_nettype wire

// *** rtl/fpo_top.sv ***
// Summary of operation
// - an all-ones supplied key is invalid and disables the override feature
// - a valid key differing from the stored key disables the override feature
// - on key match save both protection registers then load the selected ones
// - selection bit 0 replaces flash protection, bit 1 replaces eeprom protection
// - any new protection value is accepted without restriction
// - override-active bit sets when the override command succeeds
// - bad or all-ones key restores saved protection and clears override-active
// - an erased stored key permanently disables the override feature
// - an access error leaves both protection registers unmodified
// - one saved copy only; each successful override (non-restore) launch overwrites it; restore reloads it
// - direct protection writes during override are lost on restore
// - restore reloads saved values, never reset values
// - access error unless parameter index is 001, 010 or 011
// - access error when command is not permitted in current mode
// - access error when restore requested but no override active
// - access error when selection 00 and index 010 or 011
// - access error when selection 00, index 001 and valid key
// - command irq while complete flag and its enable are set
// - error irq while single fault flag and its enable are set
// - operation unaffected in wait mode; complete irq wakes the processor
// - software launches by clearing complete flag; controller sets it when done
`include "fpo_consts.svh"
`default_nettype none
module fpo_top #(
  parameter int EXEC_CYCLES = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire fpo_pkg::fpo_word_t stored_key,
  input  wire logic        cmd_permitted,
  input  wire logic        single_fault_event,
  input  wire logic        wait_mode,
  output logic             cmd_irq,
  output logic             err_irq
);
  import fpo_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  fpo_word_t  command_object_words_q [4];
  logic [2:0] command_param_index_q;
  logic       command_complete_flag_q;
  logic       access_error_flag_q;
  logic       protection_violation_flag_q;
  logic       command_complete_irq_enable_q;
  logic       single_fault_irq_enable_q;
  logic       single_fault_flag_q;
  logic [7:0] program_flash_protect_reg_q;
  logic [7:0] eeprom_protect_reg_q;
  logic       override_active_bit_q;
  logic [7:0] saved_pf_q;
  logic [7:0] saved_ee_q;
  fpo_state_e state_q;
  logic [7:0] exec_cnt_q;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic [11:0] aw_q;
  logic        aw_have_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        w_have_q;
  logic        wr_go;
  logic        wr_hit;

  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_comb begin
    case (aw_q)
      `FPO_OFF_CMD0, `FPO_OFF_CMD1, `FPO_OFF_CMD2, `FPO_OFF_CMD3, `FPO_OFF_INDEX,
      `FPO_OFF_STATUS, `FPO_OFF_CONFIG, `FPO_OFF_ERRCFG, `FPO_OFF_ERRSTAT,
      `FPO_OFF_PFPROT, `FPO_OFF_EEPROT, `FPO_OFF_PROTSTAT, `FPO_OFF_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_q          <= 12'h000;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FPO_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `FPO_RESP_OKAY : `FPO_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // decoded write strobes, low byte lane checked for the status, error status and protection registers
  logic wr_status;
  logic wr_launch;
  logic busy;
  assign busy      = !command_complete_flag_q;
  assign wr_status = wr_go && wr_hit && (aw_q == `FPO_OFF_STATUS) && ws_q[0];
  // launch by writing one to the complete flag while idle
  assign wr_launch = wr_status && w_q[`FPO_ST_COMMAND_COMPLETE_FLAG] && !busy;

  // ----------------------------------------------------------------
  // command evaluation
  // ----------------------------------------------------------------
  logic [7:0] cmd_code;
  logic [1:0] sel;
  fpo_word_t  key;
  logic       key_valid;
  logic       key_match;
  logic       feat_off;
  logic       restore;
  logic       cmd_err;
  assign cmd_code  = command_object_words_q[0][`FPO_CODE_HI:`FPO_CODE_LO];
  assign sel       = command_object_words_q[0][`FPO_SEL_HI:`FPO_SEL_LO];
  assign key       = command_object_words_q[1];
  assign key_valid = (key != `FPO_KEY_ERASED);
  assign feat_off  = (stored_key == `FPO_KEY_ERASED);
  assign key_match = key_valid && !feat_off && (key == stored_key);
  assign restore   = !key_match;

  always_comb begin
    cmd_err = 1'b0;
    if (cmd_code == `FPO_CMD_OVERRIDE) begin
      if (command_param_index_q != `FPO_IDX_1 && command_param_index_q != `FPO_IDX_2 &&
          command_param_index_q != `FPO_IDX_3) cmd_err = 1'b1;
      if (!cmd_permitted) cmd_err = 1'b1;
      if (restore && !override_active_bit_q) cmd_err = 1'b1;
      if (sel == 2'b00 && command_param_index_q != `FPO_IDX_1) cmd_err = 1'b1;
      if (sel == 2'b00 && command_param_index_q == `FPO_IDX_1 && key_valid) cmd_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer; wait_mode is ignored so commands run on in wait
  // ----------------------------------------------------------------
  logic exec_end;
  assign exec_end = (state_q == FPO_EXEC) && (exec_cnt_q == 8'(EXEC_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= FPO_IDLE;
      exec_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        FPO_IDLE: begin
          exec_cnt_q <= 8'h00;
          if (wr_launch) state_q <= FPO_EXEC;
        end
        FPO_EXEC: begin
          exec_cnt_q <= exec_cnt_q + 8'h01;
          if (exec_end) state_q <= FPO_IDLE;
        end
        default: state_q <= FPO_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic launch_err;
  assign launch_err = wr_launch && cmd_err;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command_complete_flag_q     <= 1'b1;
      access_error_flag_q         <= 1'b0;
      protection_violation_flag_q <= 1'b0;
    end else begin
      if (wr_launch && !launch_err) command_complete_flag_q <= 1'b0;
      else if (exec_end) command_complete_flag_q <= 1'b1;
      if (launch_err) access_error_flag_q <= 1'b1;
      else if (wr_status && w_q[`FPO_ST_ACCESS_ERROR_FLAG]) access_error_flag_q <= 1'b0;
      if (wr_status && w_q[`FPO_ST_PROTECTION_VIOLATION_FLAG]) protection_violation_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      single_fault_flag_q <= 1'b0;
    end else if (single_fault_event) begin
      single_fault_flag_q <= 1'b1;
    end else if (wr_go && wr_hit && aw_q == `FPO_OFF_ERRSTAT && ws_q[0] && w_q[0]) begin
      single_fault_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command object and configuration writes
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) command_object_words_q[i] <= 16'h0000;
      command_param_index_q         <= 3'h0;
      command_complete_irq_enable_q <= 1'b0;
      single_fault_irq_enable_q     <= 1'b0;
    end else if (wr_go && wr_hit && !busy) begin
      case (aw_q)
        `FPO_OFF_CMD0:   command_object_words_q[0] <= w_q[15:0];
        `FPO_OFF_CMD1:   command_object_words_q[1] <= w_q[15:0];
        `FPO_OFF_CMD2:   command_object_words_q[2] <= w_q[15:0];
        `FPO_OFF_CMD3:   command_object_words_q[3] <= w_q[15:0];
        `FPO_OFF_INDEX:  command_param_index_q     <= w_q[2:0];
        `FPO_OFF_CONFIG: command_complete_irq_enable_q <= w_q[`FPO_CFG_IRQEN];
        `FPO_OFF_ERRCFG: single_fault_irq_enable_q     <= w_q[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // protection registers and single-entry save buffer
  // ----------------------------------------------------------------
  logic do_ovr;
  assign do_ovr = wr_launch && !cmd_err && cmd_code == `FPO_CMD_OVERRIDE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      program_flash_protect_reg_q <= `FPO_PROT_RST;
      eeprom_protect_reg_q        <= `FPO_PROT_RST;
      saved_pf_q                  <= `FPO_PROT_RST;
      saved_ee_q                  <= `FPO_PROT_RST;
      override_active_bit_q       <= 1'b0;
    end else if (do_ovr && restore) begin
      program_flash_protect_reg_q <= saved_pf_q;
      eeprom_protect_reg_q        <= saved_ee_q;
      override_active_bit_q       <= 1'b0;
    end else if (do_ovr) begin
      saved_pf_q <= program_flash_protect_reg_q;
      saved_ee_q <= eeprom_protect_reg_q;
      if (sel[0]) program_flash_protect_reg_q <= command_object_words_q[2][7:0];
      if (sel[1]) eeprom_protect_reg_q <= command_object_words_q[3][7:0];
      override_active_bit_q <= 1'b1;
    end else if (wr_go && wr_hit && ws_q[0] && aw_q == `FPO_OFF_PFPROT) begin
      program_flash_protect_reg_q <= w_q[7:0];
    end else if (wr_go && wr_hit && ws_q[0] && aw_q == `FPO_OFF_EEPROT) begin
      eeprom_protect_reg_q <= w_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_irq <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      cmd_irq <= command_complete_flag_q && command_complete_irq_enable_q;
      err_irq <= single_fault_flag_q && single_fault_irq_enable_q;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `FPO_OFF_CMD0:     rd_val = {16'h0000, command_object_words_q[0]};
      `FPO_OFF_CMD1:     rd_val = {16'h0000, command_object_words_q[1]};
      `FPO_OFF_CMD2:     rd_val = {16'h0000, command_object_words_q[2]};
      `FPO_OFF_CMD3:     rd_val = {16'h0000, command_object_words_q[3]};
      `FPO_OFF_INDEX:    rd_val = {29'h0, command_param_index_q};
      `FPO_OFF_STATUS:   rd_val = {24'h0, command_complete_flag_q, 1'b0, access_error_flag_q,
                                   protection_violation_flag_q, 4'h0};
      `FPO_OFF_CONFIG:   rd_val = {24'h0, command_complete_irq_enable_q, 7'h00};
      `FPO_OFF_ERRCFG:   rd_val = {31'h0, single_fault_irq_enable_q};
      `FPO_OFF_ERRSTAT:  rd_val = {31'h0, single_fault_flag_q};
      `FPO_OFF_PFPROT:   rd_val = {24'h0, program_flash_protect_reg_q};
      `FPO_OFF_EEPROT:   rd_val = {24'h0, eeprom_protect_reg_q};
      `FPO_OFF_PROTSTAT: rd_val = {31'h0, override_active_bit_q};
      `FPO_OFF_CTRL:     rd_val = {31'h0, busy};
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FPO_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? `FPO_RESP_OKAY : `FPO_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_irq_level;
    @(posedge aclk) disable iff (!aresetn)
      ##1 cmd_irq == $past(command_complete_flag_q && command_complete_irq_enable_q);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("cmd irq mismatch");

  property p_err_irq;
    @(posedge aclk) disable iff (!aresetn)
      (single_fault_flag_q && single_fault_irq_enable_q) |=> err_irq;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("err irq missing");

  property p_ovr_sets;
    @(posedge aclk) disable iff (!aresetn) (do_ovr && !restore) |=> override_active_bit_q;
  endproperty
  a_ovr_sets: assert property (p_ovr_sets) else $error("override bit not set");

  property p_restore;
    @(posedge aclk) disable iff (!aresetn)
      (do_ovr && restore) |=> !override_active_bit_q &&
        program_flash_protect_reg_q == $past(saved_pf_q);
  endproperty
  a_restore: assert property (p_restore) else $error("restore wrong");

  property p_err_keeps;
    @(posedge aclk) disable iff (!aresetn)
      launch_err |=> $stable(program_flash_protect_reg_q) && $stable(eeprom_protect_reg_q);
  endproperty
  a_err_keeps: assert property (p_err_keeps) else $error("protection changed on error");

  property p_err_flag;
    @(posedge aclk) disable iff (!aresetn) launch_err |=> access_error_flag_q;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("access error not set");

  property p_erased_key;
    @(posedge aclk) disable iff (!aresetn)
      (do_ovr && stored_key == `FPO_KEY_ERASED) |=> !override_active_bit_q;
  endproperty
  a_erased_key: assert property (p_erased_key) else $error("erased key accepted");

  property p_done;
    @(posedge aclk) disable iff (!aresetn)
      (wr_launch && !launch_err) |=> !command_complete_flag_q ##[1:300] command_complete_flag_q;
  endproperty
  a_done: assert property (p_done) else $error("command never completed");

  c_override: cover property (@(posedge aclk) disable iff (!aresetn) do_ovr && !restore);
  c_restore: cover property (@(posedge aclk) disable iff (!aresetn) do_ovr && restore);
  c_error: cover property (@(posedge aclk) disable iff (!aresetn) launch_err);
  c_wait_wake: cover property (@(posedge aclk) disable iff (!aresetn) wait_mode && cmd_irq);
endmodule
`default_nettype wire

// *** bench/fpo_top_tb.sv ***
`include "fpo_consts.svh"
`default_nettype none
module fpo_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpo_pkg::*;

  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  fpo_word_t   stored_key;
  logic        cmd_permitted, single_fault_event, wait_mode;
  logic        cmd_irq, err_irq;
  int          err_total;
  int          n_compared;

`define FPO_TB_CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end

  fpo_top #(.EXEC_CYCLES(4)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stored_key(stored_key), .cmd_permitted(cmd_permitted),
    .single_fault_event(single_fault_event), .wait_mode(wait_mode),
    .cmd_irq(cmd_irq), .err_irq(err_irq)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------
  // bus master tasks
  // ----------------------------------------
  // waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    `FPO_TB_CHK(nm, e, d & m);
  endtask

  task automatic chk_prot(input logic [7:0] pf, input logic [7:0] ee, input logic st,
                          input logic acc);
    chk_rd(`FPO_OFF_PFPROT, 32'hff, {24'h0, pf}, "flash protection");
    chk_rd(`FPO_OFF_EEPROT, 32'hff, {24'h0, ee}, "eeprom protection");
    chk_rd(`FPO_OFF_PROTSTAT, 32'h1, {31'h0, st}, "override active");
    chk_rd(`FPO_OFF_STATUS, 32'h20, {26'h0, acc, 5'h0}, "access error");
  endtask

  // loads the command words, launches and waits for completion
  task automatic launch(input logic [7:0] code, input logic [1:0] sel, input logic [15:0] key,
                        input logic [7:0] pf, input logic [7:0] ee, input logic [2:0] idx);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    axi_wr(`FPO_OFF_CMD0, {16'h0, code, 6'h00, sel}, r);
    axi_wr(`FPO_OFF_CMD1, {16'h0, key}, r);
    axi_wr(`FPO_OFF_CMD2, {24'h0, pf}, r);
    axi_wr(`FPO_OFF_CMD3, {24'h0, ee}, r);
    axi_wr(`FPO_OFF_INDEX, {29'h0, idx}, r);
    axi_wr(`FPO_OFF_STATUS, 32'h80, r);
    do begin
      axi_rd(`FPO_OFF_STATUS, d, r);
      n++;
    end while (d[`FPO_ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 40);
    `FPO_TB_CHK("command complete", 1'b1, d[`FPO_ST_COMMAND_COMPLETE_FLAG]);
  endtask

  task automatic clr_acc;
    logic [1:0] r;
    axi_wr(`FPO_OFF_STATUS, 32'h20, r);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk_prot(`FPO_PROT_RST, `FPO_PROT_RST, 1'b0, 1'b0);
    chk_rd(`FPO_OFF_STATUS, 32'hb0, 32'h80, "status after reset");
    chk_rd(`FPO_OFF_CTRL, 32'h1, 32'h0, "busy after reset");
    axi_rd(12'h100, d, r);
    `FPO_TB_CHK("unmapped read resp", `FPO_RESP_SLVERR, r);
    `FPO_TB_CHK("unmapped read data", 32'h0, d);
    axi_wr(12'h100, 32'h1, r);
    `FPO_TB_CHK("unmapped write resp", `FPO_RESP_SLVERR, r);
    $display("test reset done");
  endtask

  task automatic t_no_override;
    logic [15:0] keys [2];
    keys = '{16'h1234, `FPO_KEY_ERASED};
    foreach (keys[i]) begin
      launch(`FPO_CMD_OVERRIDE, 2'b01, keys[i], 8'h55, 8'h66, `FPO_IDX_3);
      chk_prot(8'h00, 8'h00, 1'b0, 1'b1);
      clr_acc();
    end
    $display("test restore without override done");
  endtask

  task automatic t_override;
    logic [1:0] r;
    launch(`FPO_CMD_OVERRIDE, 2'b11, 16'h5a3c, 8'ha5, 8'h3c, `FPO_IDX_3);
    chk_prot(8'ha5, 8'h3c, 1'b1, 1'b0);
    axi_wr(`FPO_OFF_PFPROT, 32'h11, r);
    launch(`FPO_CMD_OVERRIDE, 2'b10, 16'h5a3c, 8'h00, 8'hff, `FPO_IDX_3);
    chk_prot(8'h11, 8'hff, 1'b1, 1'b0);
    axi_wr(`FPO_OFF_EEPROT, 32'h77, r);
    launch(`FPO_CMD_OVERRIDE, 2'b01, 16'h1111, 8'h00, 8'h00, `FPO_IDX_1);
    chk_prot(8'h11, 8'h3c, 1'b0, 1'b0);
    launch(`FPO_CMD_OVERRIDE, 2'b01, 16'h5a3c, 8'h00, 8'h00, `FPO_IDX_2);
    chk_prot(8'h00, 8'h3c, 1'b1, 1'b0);
    launch(`FPO_CMD_OVERRIDE, 2'b01, `FPO_KEY_ERASED, 8'h00, 8'h00, `FPO_IDX_1);
    chk_prot(8'h11, 8'h3c, 1'b0, 1'b0);
    $display("test override and restore done");
  endtask

  task automatic t_errors;
    logic [1:0] sel_t [7];
    logic [2:0] idx_t [7];
    logic       prm_t [7];
    sel_t = '{2'b11, 2'b11, 2'b11, 2'b11, 2'b00, 2'b00, 2'b00};
    idx_t = '{3'h0, 3'h4, 3'h7, 3'h3, 3'h2, 3'h3, 3'h1};
    prm_t = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    launch(`FPO_CMD_OVERRIDE, 2'b11, 16'h5a3c, 8'h22, 8'h44, `FPO_IDX_3);
    foreach (sel_t[i]) begin
      @(posedge aclk);
      cmd_permitted <= prm_t[i];
      launch(`FPO_CMD_OVERRIDE, sel_t[i], 16'h5a3c, 8'h99, 8'h88, idx_t[i]);
      chk_prot(8'h22, 8'h44, 1'b1, 1'b1);
      clr_acc();
    end
    cmd_permitted <= 1'b1;
    $display("test access errors done");
  endtask

  task automatic t_erased;
    @(posedge aclk);
    stored_key <= `FPO_KEY_ERASED;
    launch(`FPO_CMD_OVERRIDE, 2'b11, 16'h5a3c, 8'h99, 8'h88, `FPO_IDX_3);
    chk_prot(8'h11, 8'h3c, 1'b0, 1'b0);
    launch(`FPO_CMD_OVERRIDE, 2'b11, 16'h5a3c, 8'h99, 8'h88, `FPO_IDX_3);
    chk_prot(8'h11, 8'h3c, 1'b0, 1'b1);
    clr_acc();
    stored_key <= 16'h5a3c;
    $display("test erased key done");
  endtask

  task automatic t_irq;
    logic [1:0] r;
    logic       low_seen;
    int         n;
    low_seen = 1'b0;
    wait_mode <= 1'b1;
    axi_wr(`FPO_OFF_CONFIG, 32'h80, r);
    repeat (3) @(posedge aclk);
    `FPO_TB_CHK("cmd irq idle", 1'b1, cmd_irq);
    axi_wr(`FPO_OFF_CMD0, 32'h1200, r);
    axi_wr(`FPO_OFF_STATUS, 32'h80, r);
    for (n = 0; n < 40 && !(low_seen && cmd_irq === 1'b1); n++) begin
      @(posedge aclk);
      if (cmd_irq === 1'b0) low_seen = 1'b1;
    end
    `FPO_TB_CHK("cmd irq busy", 1'b1, low_seen);
    `FPO_TB_CHK("cmd irq wake", 1'b1, cmd_irq);
    axi_wr(`FPO_OFF_CONFIG, 32'h0, r);
    repeat (3) @(posedge aclk);
    `FPO_TB_CHK("cmd irq masked", 1'b0, cmd_irq);
    single_fault_event <= 1'b1;
    @(posedge aclk);
    single_fault_event <= 1'b0;
    repeat (3) @(posedge aclk);
    `FPO_TB_CHK("err irq masked", 1'b0, err_irq);
    chk_rd(`FPO_OFF_ERRSTAT, 32'h1, 32'h1, "single fault flag");
    axi_wr(`FPO_OFF_ERRCFG, 32'h1, r);
    repeat (3) @(posedge aclk);
    `FPO_TB_CHK("err irq raised", 1'b1, err_irq);
    axi_wr(`FPO_OFF_ERRSTAT, 32'h1, r);
    repeat (3) @(posedge aclk);
    `FPO_TB_CHK("err irq cleared", 1'b0, err_irq);
    $display("test interrupts done");
  endtask

  // ----------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_of_test();
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    stored_key = 16'h5a3c;
    cmd_permitted = 1'b1;
    single_fault_event = 1'b0;
    wait_mode = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_no_override();
    t_override();
    t_errors();
    t_erased();
    t_irq();
    end_of_test();
  end
endmodule
`default_nettype wire
